/* core/flash_pkg.sv */
// Purpose: constants and types of the flash program/erase control
// Assumes: AHB-Lite word registers at 32-bit aligned offsets
// Notes:   offsets compared on haddr[7:0]
package flash_pkg;
    localparam logic [7:0]  OFS_CTRL_ONE  = 8'h00;
    localparam logic [7:0]  OFS_CTRL_TWO  = 8'h04;
    localparam logic [7:0]  OFS_BLK_ONE   = 8'h08;
    localparam logic [7:0]  OFS_BLK_TWO   = 8'h0c;
    localparam logic [7:0]  OFS_OVL_CTRL  = 8'h10;
    localparam logic [7:0]  OFS_STATUS    = 8'h14;
    localparam int          B_STROBE      = 0;
    localparam int          B_WIPE_ON     = 1;
    localparam int          B_WR_CHECK    = 2;
    localparam int          B_WIPE_AUDIT  = 3;
    localparam int          B_UNLOCK      = 6;
    localparam int          B_ERR         = 7;
    localparam int          B_OVL_EN      = 3;
    localparam logic [7:0]  CTRL_RST      = 8'h00;
    localparam logic [7:0]  BLK_RST       = 8'h00;
    localparam logic [3:0]  OVL_RST       = 4'h0;
    localparam logic [23:0] OVL_RAM_BASE  = 24'hff_a000;
    localparam logic [23:0] OVL_RAM_LAST  = 24'hff_afff;
    localparam logic [7:0]  FILL_BYTE     = 8'hff;
    localparam int          UNIT_BYTES    = 128;
    typedef enum logic [2:0] {
        M_IDLE  = 3'b000,
        M_PROG  = 3'b001,
        M_ERASE = 3'b010,
        M_PVER  = 3'b011,
        M_EVER  = 3'b100
    } mode_t;
    typedef struct packed {
        logic flash_rd;
        logic exc_start;
        logic sleep_exec;
        logic bus_release;
    } cpu_evt_t;
    typedef struct packed {
        logic        en;
        logic [23:0] addr;
        logic [7:0]  data;
    } flash_wr_t;
endpackage

/* core/flash_program_erase_control.sv */
// Purpose: program/erase sequencing, protection and RAM overlay of flash
// Assumes: single AHB-Lite master, zero wait states, word transfers
// Notes:   hresetn is the power-on reset; watchdog reset is a sync input
//
// The AHB-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module flash_program_erase_control (
    // AHB-Lite slave
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic [31:0]               hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    // System state
    input  wire logic                 wdt_reset,
    input  wire logic                 standby_entry,
    input  wire logic                 hw_standby_n,
    input  wire logic                 boot_active,
    input  wire flash_pkg::cpu_evt_t  cpu_evt,
    // Flash write and address path
    input  wire flash_pkg::flash_wr_t flash_wr,
    input  wire logic [23:0]          cpu_addr,
    input  wire logic [6:0]           latch_rd_idx,
    // Flash control outputs
    output logic                      prog_en,
    output logic                      erase_en,
    output logic [15:0]               erase_blocks,
    output logic                      pv_mode,
    output logic                      ev_mode,
    output logic                      irq_inhibit,
    output logic                      flash_read_ok,
    output logic                      flash_halt,
    output logic                      ovl_hit,
    output logic [23:0]               ovl_ram_addr,
    output logic                      vfy_armed,
    output logic                      vfy_long,
    output logic [23:0]               vfy_addr,
    output logic [23:0]               latch_base,
    output logic                      latch_full,
    output logic [7:0]                latch_rd_data
);
    // ********************************
    // Functions and state
    // ********************************
    function automatic logic onehot16(input logic [15:0] v);
        logic [4:0] n;
        n = 5'd0;
        for (int i = 0; i < 16; i++) begin
            n = n + {4'd0, v[i]};
        end
        return n == 5'd1;
    endfunction

    function automatic logic [23:0] ovl_flash_base(input logic [2:0] s);
        return {9'd0, s, 12'h000};
    endfunction

    logic [7:0]         ctl1_r;
    logic               err_r;
    logic [7:0]         blk1_r;
    logic [7:0]         blk2_r;
    logic [3:0]         ovl_r;
    flash_pkg::mode_t   mode_r;
    flash_pkg::mode_t   mode_nxt;
    logic               hws_meta_r;
    logic               hws_q_r;
    logic               ph_wr_r;
    logic               ph_rd_r;
    logic [7:0]         ph_addr_r;
    logic [7:0]         latch_mem [0:flash_pkg::UNIT_BYTES-1];
    logic [7:0]         cnt_r;
    logic               busy;
    logic               err_set;
    logic               permit;
    logic               clr_regs;
    logic               addr_ph;
    logic               ovl_en;
    logic [15:0]        blk_all;
    logic [23:0]        ovl_base;
    logic               latch_acc;

    assign ovl_en  = ovl_r[flash_pkg::B_OVL_EN];
    assign ovl_base = ovl_flash_base(ovl_r[2:0]);
    // One gate for memory and counter, so refused bytes never land
    assign latch_acc = flash_wr.en && !busy && ctl1_r[flash_pkg::B_UNLOCK]
                       && mode_nxt == flash_pkg::M_IDLE
                       && cnt_r < 8'(flash_pkg::UNIT_BYTES);
    assign blk_all = {blk2_r, blk1_r};
    assign busy    = (mode_r == flash_pkg::M_PROG) || (mode_r == flash_pkg::M_ERASE);
    assign err_set = busy && (|cpu_evt);
    assign permit  = ctl1_r[flash_pkg::B_UNLOCK] && !ovl_en && !err_r;
    assign clr_regs = wdt_reset || standby_entry || hws_q_r;
    assign addr_ph = hsel && hready && htrans[1] && (hsize == 3'b010);

    // ********************************
    // Hardware standby pin sync
    // ********************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hws_meta_r <= 1'b0;
            hws_q_r    <= 1'b0;
        end else begin
            hws_meta_r <= !hw_standby_n;
            hws_q_r    <= hws_meta_r;
        end
    end

    // ********************************
    // AHB-Lite slave
    // ********************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_wr_r   <= 1'b0;
            ph_rd_r   <= 1'b0;
            ph_addr_r <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            ph_wr_r   <= addr_ph && hwrite;
            ph_rd_r   <= addr_ph && !hwrite;
            ph_addr_r <= haddr[7:0];
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Read data sampled in address phase so hrdata is a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ph && !hwrite) begin
            unique case (haddr[7:0])
                flash_pkg::OFS_CTRL_ONE: hrdata <= {24'd0, ctl1_r};
                flash_pkg::OFS_CTRL_TWO: hrdata <= {24'd0, err_r, 7'd0};
                flash_pkg::OFS_BLK_ONE:  hrdata <= {24'd0, blk1_r};
                flash_pkg::OFS_BLK_TWO:  hrdata <= {24'd0, blk2_r};
                flash_pkg::OFS_OVL_CTRL: hrdata <= {28'd0, ovl_r};
                flash_pkg::OFS_STATUS:   hrdata <= {8'd0, 5'd0, mode_r, cnt_r, 8'd0};
                default:                 hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // ********************************
    // Control registers
    // ********************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl1_r <= flash_pkg::CTRL_RST;
            blk1_r <= flash_pkg::BLK_RST;
            blk2_r <= flash_pkg::BLK_RST;
        end else if (clr_regs) begin
            ctl1_r <= flash_pkg::CTRL_RST;
            blk1_r <= flash_pkg::BLK_RST;
            blk2_r <= flash_pkg::BLK_RST;
        end else if (ph_wr_r) begin
            if (ph_addr_r == flash_pkg::OFS_CTRL_ONE) begin
                ctl1_r <= hwdata[7:0];
                // Strobes dropped unless entry is allowed
                if (!(hwdata[flash_pkg::B_UNLOCK] && !ovl_en && !err_r)) begin
                    ctl1_r[flash_pkg::B_STROBE]  <= 1'b0;
                    ctl1_r[flash_pkg::B_WIPE_ON] <= 1'b0;
                end
            end
            if (ph_addr_r == flash_pkg::OFS_BLK_ONE) begin
                blk1_r <= hwdata[7:0];
            end
            if (ph_addr_r == flash_pkg::OFS_BLK_TWO) begin
                blk2_r <= hwdata[7:0];
            end
        end
    end

    // Overlay control cleared by power-on and watchdog reset; it survives standby
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ovl_r <= flash_pkg::OVL_RST;
        end else if (wdt_reset) begin
            ovl_r <= flash_pkg::OVL_RST;
        end else if (ph_wr_r && ph_addr_r == flash_pkg::OFS_OVL_CTRL) begin
            ovl_r <= hwdata[3:0];
        end
    end

    // Error flag: only power-on reset or hardware standby clears it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_r <= 1'b0;
        end else if (err_set) begin
            err_r <= 1'b1;
        end else if (hws_q_r) begin
            err_r <= 1'b0;
        end
    end

    // ********************************
    // Mode selection
    // ********************************
    always_comb begin
        mode_nxt = flash_pkg::M_IDLE;
        if (clr_regs || err_set) begin
            mode_nxt = flash_pkg::M_IDLE;
        end else if (permit && ctl1_r[flash_pkg::B_STROBE]) begin
            mode_nxt = flash_pkg::M_PROG;
        end else if (permit && ctl1_r[flash_pkg::B_WIPE_ON] && onehot16(blk_all)) begin
            mode_nxt = flash_pkg::M_ERASE;
        end else if (ctl1_r[flash_pkg::B_WR_CHECK]) begin
            mode_nxt = flash_pkg::M_PVER;
        end else if (ctl1_r[flash_pkg::B_WIPE_AUDIT]) begin
            mode_nxt = flash_pkg::M_EVER;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_r       <= flash_pkg::M_IDLE;
            prog_en      <= 1'b0;
            erase_en     <= 1'b0;
            erase_blocks <= 16'h0000;
            pv_mode      <= 1'b0;
            ev_mode      <= 1'b0;
        end else begin
            mode_r   <= mode_nxt;
            prog_en  <= mode_nxt == flash_pkg::M_PROG;
            erase_en <= mode_nxt == flash_pkg::M_ERASE;
            pv_mode  <= mode_nxt == flash_pkg::M_PVER;
            ev_mode  <= mode_nxt == flash_pkg::M_EVER;
            erase_blocks <= (mode_nxt == flash_pkg::M_ERASE) ? blk_all : 16'h0000;
        end
    end

    // ********************************
    // System status outputs
    // ********************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_inhibit   <= 1'b0;
            flash_read_ok <= 1'b0;
            flash_halt    <= 1'b0;
        end else begin
            irq_inhibit <= boot_active || mode_nxt == flash_pkg::M_PROG
                           || mode_nxt == flash_pkg::M_ERASE;
            flash_halt  <= standby_entry || hws_q_r;
            flash_read_ok <= !(standby_entry || hws_q_r)
                             && (!ctl1_r[flash_pkg::B_UNLOCK]
                                 || mode_nxt == flash_pkg::M_PVER
                                 || mode_nxt == flash_pkg::M_EVER);
        end
    end

    // ********************************
    // RAM overlay
    // ********************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ovl_hit      <= 1'b0;
            ovl_ram_addr <= 24'h00_0000;
        end else begin
            // RAM addresses always reach RAM; only flash side is steered
            ovl_hit <= ovl_en && cpu_addr[23:12] == ovl_base[23:12];
            ovl_ram_addr <= {flash_pkg::OVL_RAM_BASE[23:12], cpu_addr[11:0]};
        end
    end

    // ********************************
    // Program latch and verify address
    // ********************************
    always_ff @(posedge hclk) begin
        if (latch_acc) begin
            latch_mem[flash_wr.addr[6:0]] <= flash_wr.data;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            latch_rd_data <= 8'h00;
        end else begin
            latch_rd_data <= latch_mem[latch_rd_idx];
        end
    end

    // Count restarts after each program pulse so a new unit can load
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r      <= 8'h00;
            latch_base <= 24'h00_0000;
            latch_full <= 1'b0;
        end else if (clr_regs || (mode_r == flash_pkg::M_PROG && mode_nxt != flash_pkg::M_PROG)) begin
            cnt_r      <= 8'h00;
            latch_full <= 1'b0;
        end else if (latch_acc) begin
            if (cnt_r == 8'h00) begin
                latch_base <= {flash_wr.addr[23:7], 7'd0};
            end
            cnt_r      <= cnt_r + 8'h01;
            latch_full <= cnt_r == 8'(flash_pkg::UNIT_BYTES - 1);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vfy_armed <= 1'b0;
            vfy_long  <= 1'b0;
            vfy_addr  <= 24'h00_0000;
        end else if (!(pv_mode || ev_mode) || clr_regs) begin
            vfy_armed <= 1'b0;
        end else if (flash_wr.en && flash_wr.data == flash_pkg::FILL_BYTE
                     && flash_wr.addr[1:0] == 2'b00) begin
            vfy_armed <= 1'b1;
            vfy_long  <= ev_mode;
            vfy_addr  <= flash_wr.addr;
        end
    end

    // ********************************
    // Assertions
    // ********************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_ovl_block;
        ovl_en |=> !prog_en && !erase_en;
    endproperty
    a_ovl_block: assert property (p_ovl_block) else $error("overlay let program or erase run");

    property p_prog_stop;
        $fell(ctl1_r[flash_pkg::B_STROBE]) |=> !prog_en;
    endproperty
    a_prog_stop: assert property (p_prog_stop) else $error("program outlived strobe");

    property p_erase_stop;
        !ctl1_r[flash_pkg::B_WIPE_ON] |=> !erase_en;
    endproperty
    a_erase_stop: assert property (p_erase_stop) else $error("erase without wiping_on");

    property p_unlock;
        !ctl1_r[flash_pkg::B_UNLOCK] |=> !prog_en && !erase_en;
    endproperty
    a_unlock: assert property (p_unlock) else $error("locked flash entered program or erase");

    property p_blk_prot;
        (blk_all == 16'h0000) |=> !erase_en;
    endproperty
    a_blk_prot: assert property (p_blk_prot) else $error("erase with no block selected");

    property p_err_set;
        busy && cpu_evt.flash_rd ##1 !hws_q_r |-> err_r;
    endproperty
    a_err_set: assert property (p_err_set) else $error("flash read while busy missed error");

    property p_err_abort;
        err_r |=> !prog_en && !erase_en;
    endproperty
    a_err_abort: assert property (p_err_abort) else $error("error did not abort");

    property p_err_hold;
        err_r && !hws_q_r |=> err_r;
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("error flag cleared early");

    property p_irq;
        prog_en || erase_en |-> irq_inhibit;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupts open while busy");

    property p_clr;
        wdt_reset |=> ctl1_r == 8'h00 && blk_all == 16'h0000 ##1 !prog_en;
    endproperty
    a_clr: assert property (p_clr) else $error("reset left control registers set");

    property p_ovl_off;
        !ovl_en |=> !ovl_hit;
    endproperty
    a_ovl_off: assert property (p_ovl_off) else $error("overlay hit while disabled");

    c_prog:  cover property (prog_en ##1 !prog_en);
    c_erase: cover property (erase_en && onehot16(erase_blocks));
    c_err:   cover property ($rose(err_r));
    c_ovl:   cover property (ovl_hit);
endmodule
`default_nettype wire

/* verif/flash_program_erase_control_test.sv */
// Purpose: self-checking bench of the flash program/erase control
// Assumes: zero-wait AHB-Lite slave, one word per register
// Notes:   expected values come from the register map and mode codes
`timescale 1ns/10ps
`default_nettype none
module flash_program_erase_control_test;
    logic                 hclk = 1'b0;
    logic                 hresetn = 1'b0;
    logic                 hsel = 1'b0;
    logic                 hwrite = 1'b0;
    logic [31:0]          haddr = 32'h0;
    logic [1:0]           htrans = 2'h0;
    logic [2:0]           hsize = 3'h2;
    logic [31:0]          hwdata = 32'h0;
    logic                 hready;
    logic [31:0]          hrdata;
    logic                 hreadyout, hresp, wdt_reset = 1'b0, standby_entry = 1'b0;
    logic                 hw_standby_n = 1'b1, boot_active = 1'b0;
    flash_pkg::cpu_evt_t  cpu_evt = '0;
    flash_pkg::flash_wr_t flash_wr = '0;
    logic [23:0]          cpu_addr = 24'h00_0000;
    logic [6:0]           latch_rd_idx = 7'h00;
    logic                 prog_en, erase_en, pv_mode, ev_mode, irq_inhibit, flash_read_ok;
    logic                 flash_halt, ovl_hit, vfy_armed, vfy_long, latch_full;
    logic [15:0]          erase_blocks;
    logic [23:0]          ovl_ram_addr, vfy_addr, latch_base;
    logic [7:0]           latch_rd_data;
    int                   fail_count = 0;
    int                   num_checks = 0;

    assign hready = hreadyout;
    always #2.5 hclk = ~hclk;

    flash_program_erase_control flash_program_erase_control_inst (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
        .hreadyout, .hresp, .wdt_reset, .standby_entry, .hw_standby_n, .boot_active, .cpu_evt,
        .flash_wr, .cpu_addr, .latch_rd_idx, .prog_en, .erase_en, .erase_blocks, .pv_mode,
        .ev_mode, .irq_inhibit, .flash_read_ok, .flash_halt, .ovl_hit, .ovl_ram_addr,
        .vfy_armed, .vfy_long, .vfy_addr, .latch_base, .latch_full, .latch_rd_data
    );

    // ****************************************
    // Bus, wait and compare tasks
    // ****************************************
    task automatic test_done();
        if (fail_count == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Bounded, so a stuck slave ends the run instead of hanging it
    task automatic bus_wait();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 20);
        if (hready !== 1'b1) begin
            fail_count++;
            test_done();
        end
    endtask

    task automatic aph(input logic [7:0] a, input logic w);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        bus_wait();
        hsel <= 1'b0;
        htrans <= 2'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        aph(a, 1'b1);
        hwdata <= {24'h00_0000, d};
        bus_wait();
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        aph(a, 1'b0);
        bus_wait();
        d = hrdata;
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] d;
        rd(a, d);
        chk(32'(d[7:0]), 32'(e));
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask

    task automatic fw(input logic [23:0] a, input logic [7:0] d);
        @(posedge hclk);
        flash_wr <= {1'b1, a, d};
        @(posedge hclk);
        flash_wr.en <= 1'b0;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_basic();
        rc(8'h3c, 8'h00);
        wr(8'h00, 8'h01);
        step(2);
        chk(32'(prog_en), 32'h0);
        rc(8'h00, 8'h00);
        chk(32'(hresp), 32'h0);
        @(posedge hclk);
        boot_active <= 1'b1;
        step(2);
        chk(32'(irq_inhibit), 32'h1);
        @(posedge hclk);
        boot_active <= 1'b0;
    endtask

    task automatic t_latch();
        logic [31:0] d;
        wr(8'h00, 8'h40);
        // Short unit padded with the fill byte, as software must
        for (int i = 0; i < 128; i++) begin
            fw(24'h00_1080 + 24'(i), (i > 100) ? 8'hff : 8'(i));
        end
        @(posedge hclk);
        latch_rd_idx <= 7'h78;
        step(2);
        chk(32'({latch_full, latch_base}), 32'h0100_1080);
        chk(32'(latch_rd_data), 32'hff);
        rd(8'h14, d);
        chk(32'(d[15:8]), 32'h80);
        wr(8'h00, 8'h41);
        step(1);
        chk(32'(prog_en), 32'h1);
        step(1);
        chk(32'(irq_inhibit), 32'h1);
        rd(8'h14, d);
        chk(32'(d[18:16]), 32'h1);
        wr(8'h00, 8'h40);
        step(1);
        chk(32'(prog_en), 32'h0);
        step(1);
        chk(32'(latch_full), 32'h0);
    endtask

    task automatic t_verify();
        wr(8'h00, 8'h44);
        step(2);
        chk(32'({pv_mode, flash_read_ok}), 32'h3);
        fw(24'h00_1084, 8'hff);
        step(2);
        chk(32'({vfy_armed, vfy_long, vfy_addr}), 32'h0200_1084);
        wr(8'h00, 8'h48);
        step(2);
        chk(32'(ev_mode), 32'h1);
        fw(24'h00_2000, 8'hff);
        step(2);
        chk(32'({vfy_armed, vfy_long}), 32'h3);
        wr(8'h00, 8'h40);
        step(2);
        chk(32'({flash_read_ok, ev_mode, vfy_armed}), 32'h0);
    endtask

    task automatic t_erase();
        wr(8'h00, 8'h42);
        step(2);
        chk(32'(erase_en), 32'h0);
        wr(8'h0c, 8'h01);
        step(2);
        chk(32'({erase_en, erase_blocks}), 32'h1_0100);
        wr(8'h00, 8'h40);
        step(1);
        chk(32'(erase_en), 32'h0);
        wr(8'h08, 8'h01);
        wr(8'h00, 8'h42);
        step(2);
        chk(32'(erase_en), 32'h0);
        wr(8'h00, 8'h40);
        wr(8'h08, 8'h00);
        wr(8'h0c, 8'h00);
    endtask

    task automatic t_overlay();
        wr(8'h10, 8'h0a);
        @(posedge hclk);
        cpu_addr <= 24'h00_2abc;
        step(2);
        chk(32'({ovl_hit, ovl_ram_addr}), 32'h01ff_aabc);
        wr(8'h00, 8'h41);
        step(2);
        chk(32'(prog_en), 32'h0);
        rc(8'h00, 8'h40);
        wr(8'h10, 8'h02);
        step(2);
        chk(32'(ovl_hit), 32'h0);
    endtask

    task automatic t_error();
        for (int i = 0; i < 4; i++) begin
            wr(8'h00, 8'h41);
            step(2);
            chk(32'(prog_en), 32'h1);
            @(posedge hclk);
            cpu_evt <= flash_pkg::cpu_evt_t'(4'h1 << i);
            @(posedge hclk);
            cpu_evt <= '0;
            step(1);
            chk(32'(prog_en), 32'h0);
            rc(8'h04, 8'h80);
            rc(8'h00, 8'h41);
            wr(8'h00, 8'h45);
            step(2);
            chk(32'({prog_en, pv_mode}), 32'h1);
            rc(8'h00, 8'h44);
            @(posedge hclk);
            wdt_reset <= 1'b1;
            @(posedge hclk);
            wdt_reset <= 1'b0;
            step(2);
            rc(8'h04, 8'h80);
            rc(8'h00, 8'h00);
            @(posedge hclk);
            hw_standby_n <= 1'b0;
            step(4);
            @(posedge hclk);
            hw_standby_n <= 1'b1;
            step(4);
            rc(8'h04, 8'h00);
        end
    endtask

    task automatic t_standby();
        wr(8'h08, 8'h01);
        wr(8'h00, 8'h41);
        step(2);
        chk(32'(prog_en), 32'h1);
        @(posedge hclk);
        standby_entry <= 1'b1;
        step(2);
        chk(32'({prog_en, flash_halt}), 32'h1);
        rc(8'h00, 8'h00);
        rc(8'h08, 8'h00);
        @(posedge hclk);
        standby_entry <= 1'b0;
        // Software lets 100 us pass before touching the flash again
        step(20000);
        chk(32'(flash_halt), 32'h0);
    endtask

    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        t_basic();
        t_latch();
        t_verify();
        t_erase();
        t_overlay();
        t_error();
        t_standby();
        test_done();
    end
endmodule
`default_nettype wire
